// >>> verilog/dic_irq_clear_status.sv
// Interrupt flag bookkeeping for a two-channel transfer engine
//
// Overview of operation
// - One to bit 1 clears channel 1 end
// - One to bit 0 clears channel 0 end
// - Error status bit 1 shows enabled channel 1 error
// - Error status bit 0 shows enabled channel 0 error
// - Writing one to error bit 1 clears it
// - Writing one to error bit 0 clears it
// - Combined status is enabled end or error
// - Raw end flag kept before enable masking
// - Raw error flag kept before enable masking
`timescale 1ns/1ps

module dic_irq_clear_status
  import dic_pkg::*;
#(
  parameter int CHANNELS = DIC_CHANNELS
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire dic_bus_req_t bus_in,
  output logic [DIC_DATA_W-1:0] rdata_out,
  input wire logic [CHANNELS-1:0] tc_event_in,
  input wire logic [CHANNELS-1:0] err_event_in,
  input wire logic [CHANNELS-1:0] tc_enable_in,
  input wire logic [CHANNELS-1:0] err_enable_in,
  output logic [CHANNELS-1:0] raw_tc_out,
  output logic [CHANNELS-1:0] raw_err_out,
  output logic [CHANNELS-1:0] masked_tc_out,
  output logic [CHANNELS-1:0] masked_err_out,
  output logic [CHANNELS-1:0] combined_status_out,
  output logic irq_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Both event groups share one 32-bit sticky register
  if (CHANNELS < 1 || 2 * CHANNELS > DIC_DATA_W) begin : g_bad_channels
    $error("CHANNELS must lie between 1 and 16");
  end

  localparam int EW = 2 * CHANNELS;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DIC_DATA_W-1:0] rdata;
    logic [CHANNELS-1:0] masked_tc;
    logic [CHANNELS-1:0] masked_err;
    logic [CHANNELS-1:0] combined;
    logic [EW-1:0] evt_status;
    logic [EW-1:0] evt_mask;
    logic irq;
  } dic_state_t;

  dic_state_t state;
  dic_state_t next_state;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic aligned;
  logic wr_tc_clear;
  logic wr_err_clear;
  logic wr_evt_mask;
  logic rd_evt_status;
  logic [CHANNELS-1:0] tc_clear;
  logic [CHANNELS-1:0] err_clear;
  logic [CHANNELS-1:0] raw_tc;
  logic [CHANNELS-1:0] raw_err;
  logic [CHANNELS-1:0] next_raw_tc;
  logic [CHANNELS-1:0] next_raw_err;
  logic [EW-1:0] evt_set;

  // Misaligned addresses hit nothing and read as zero
  assign aligned = (bus_in.addr[1:0] == 2'h0);
  assign wr_tc_clear = bus_in.wr && aligned &&
                       (bus_in.addr == DIC_OFS_TC_CLEAR);
  assign wr_err_clear = bus_in.wr && aligned &&
                        (bus_in.addr == DIC_OFS_ERR_CLEAR);
  assign wr_evt_mask = bus_in.wr && aligned &&
                       (bus_in.addr == DIC_OFS_EVT_MASK);
  assign rd_evt_status = bus_in.rd && aligned &&
                         (bus_in.addr == DIC_OFS_EVT_STATUS);

  assign tc_clear = wr_tc_clear ? bus_in.wdata[CHANNELS-1:0] :
                    {CHANNELS{1'b0}};
  assign err_clear = wr_err_clear ? bus_in.wdata[CHANNELS-1:0] :
                     {CHANNELS{1'b0}};

  assign evt_set = {err_event_in, tc_event_in};

  // ************************************************************
  // Raw flag cells
  // ************************************************************
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    // Raw end flag ahead of the mask
    dic_flag_cell u_tc (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .set_in(tc_event_in[ch]),
      .clear_in(tc_clear[ch]),
      .flag_out(raw_tc[ch])
    );
    // Raw error flag ahead of the mask
    dic_flag_cell u_err (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .set_in(err_event_in[ch]),
      .clear_in(err_clear[ch]),
      .flag_out(raw_err[ch])
    );
    assign next_raw_tc[ch] =
      dic_next_flag(raw_tc[ch], tc_event_in[ch], tc_clear[ch]);
    assign next_raw_err[ch] =
      dic_next_flag(raw_err[ch], err_event_in[ch], err_clear[ch]);
  end

  // ************************************************************
  // Read data
  // ************************************************************
  function automatic logic [DIC_DATA_W-1:0] widen(
    input logic [EW-1:0] value
  );
    logic [DIC_DATA_W-1:0] result;
    result = DIC_READ_ZERO;
    result[EW-1:0] = value;
    widen = result;
  endfunction

  function automatic logic [DIC_DATA_W-1:0] widen_ch(
    input logic [CHANNELS-1:0] value
  );
    logic [DIC_DATA_W-1:0] result;
    result = DIC_READ_ZERO;
    result[CHANNELS-1:0] = value;
    widen_ch = result;
  endfunction

  logic [DIC_DATA_W-1:0] read_mux;

  always_comb begin
    read_mux = DIC_READ_ZERO;
    if (bus_in.rd && aligned) begin
      unique case (bus_in.addr)
        DIC_OFS_COMBINED: begin
          read_mux = widen_ch(state.combined);
        end
        DIC_OFS_TC_STATUS: begin
          read_mux = widen_ch(state.masked_tc);
        end
        // Error status shows masked error flags
        DIC_OFS_ERR_STATUS: begin
          read_mux = widen_ch(state.masked_err);
        end
        DIC_OFS_RAW_TC: begin
          read_mux = widen_ch(raw_tc);
        end
        DIC_OFS_RAW_ERR: begin
          read_mux = widen_ch(raw_err);
        end
        DIC_OFS_EVT_STATUS: begin
          read_mux = widen(state.evt_status);
        end
        DIC_OFS_EVT_MASK: begin
          read_mux = widen(state.evt_mask);
        end
        // Clear registers are write-only and read as zero
        default: begin
          read_mux = DIC_READ_ZERO;
        end
      endcase
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_state = state;
    next_state.rdata = read_mux;
    // Masked flags follow the cleared raw flags at once
    next_state.masked_tc = next_raw_tc & tc_enable_in;
    next_state.masked_err = next_raw_err & err_enable_in;
    // Either enabled request raises the channel
    next_state.combined = next_state.masked_tc | next_state.masked_err;
    if (wr_evt_mask) begin
      next_state.evt_mask = bus_in.wdata[EW-1:0];
    end
    // Read returns the old value; new events survive the read
    next_state.evt_status = evt_set |
      (state.evt_status & ~{EW{rd_evt_status}});
    next_state.irq = |(next_state.evt_status & next_state.evt_mask);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state.rdata <= DIC_RDATA_RESET;
      state.masked_tc <= '0;
      state.masked_err <= '0;
      state.combined <= '0;
      state.evt_status <= '0;
      state.evt_mask <= '0;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata_out = state.rdata;
  assign raw_tc_out = raw_tc;
  assign raw_err_out = raw_err;
  assign masked_tc_out = state.masked_tc;
  assign masked_err_out = state.masked_err;
  assign combined_status_out = state.combined;
  assign irq_out = state.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_ch1_end_clear: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_tc_clear && bus_in.wdata[DIC_CH1_BIT] &&
    !tc_event_in[DIC_CH1_BIT]
    |=> !raw_tc_out[DIC_CH1_BIT] && !masked_tc_out[DIC_CH1_BIT])
    else $error("Channel 1 end flag not cleared");

  a_ch0_end_clear: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_tc_clear && bus_in.wdata[DIC_CH0_BIT] &&
    !tc_event_in[DIC_CH0_BIT]
    |=> !raw_tc_out[DIC_CH0_BIT] && !masked_tc_out[DIC_CH0_BIT])
    else $error("Channel 0 end flag not cleared");

  a_end_zero_keeps: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_tc_clear && !bus_in.wdata[DIC_CH0_BIT] && raw_tc[DIC_CH0_BIT]
    |=> raw_tc_out[DIC_CH0_BIT])
    else $error("Zero write disturbed channel 0 end flag");

  a_end_zero_ch1: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_tc_clear && !bus_in.wdata[DIC_CH1_BIT] && raw_tc[DIC_CH1_BIT]
    |=> raw_tc_out[DIC_CH1_BIT])
    else $error("Zero write disturbed channel 1 end flag");

  a_ch1_err_masked: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ##1 masked_err_out[DIC_CH1_BIT] ==
    (raw_err_out[DIC_CH1_BIT] && $past(err_enable_in[DIC_CH1_BIT])))
    else $error("Channel 1 error status wrong");

  a_ch0_err_masked: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ##1 masked_err_out[DIC_CH0_BIT] ==
    (raw_err_out[DIC_CH0_BIT] && $past(err_enable_in[DIC_CH0_BIT])))
    else $error("Channel 0 error status wrong");

  a_ch0_err_read: assert property (
    @(posedge clock_in) disable iff (rst_in)
    bus_in.rd && aligned && bus_in.addr == DIC_OFS_ERR_STATUS
    |=> rdata_out[DIC_CH0_BIT] == $past(masked_err_out[DIC_CH0_BIT]))
    else $error("Channel 0 error status read wrong");

  a_ch1_err_clear: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_err_clear && bus_in.wdata[DIC_CH1_BIT] &&
    !err_event_in[DIC_CH1_BIT]
    |=> !raw_err_out[DIC_CH1_BIT] && !masked_err_out[DIC_CH1_BIT])
    else $error("Channel 1 error flag not cleared");

  a_ch0_err_clear: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_err_clear && bus_in.wdata[DIC_CH0_BIT] &&
    !err_event_in[DIC_CH0_BIT]
    |=> !raw_err_out[DIC_CH0_BIT] && !masked_err_out[DIC_CH0_BIT])
    else $error("Channel 0 error flag not cleared");

  a_err1_zero_keeps: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_err_clear && !bus_in.wdata[DIC_CH1_BIT] && raw_err[DIC_CH1_BIT]
    |=> raw_err_out[DIC_CH1_BIT])
    else $error("Zero write disturbed channel 1 error flag");

  a_err0_zero_keeps: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_err_clear && !bus_in.wdata[DIC_CH0_BIT] && raw_err[DIC_CH0_BIT]
    |=> raw_err_out[DIC_CH0_BIT])
    else $error("Zero write disturbed channel 0 error flag");

  a_combined_or: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ##1 combined_status_out ==
    ((raw_tc_out & $past(tc_enable_in)) |
     (raw_err_out & $past(err_enable_in))))
    else $error("Combined status is not end or error");

  a_end_event_raw: assert property (
    @(posedge clock_in) disable iff (rst_in)
    tc_event_in[DIC_CH1_BIT]
    |=> raw_tc_out[DIC_CH1_BIT] &&
        masked_tc_out[DIC_CH1_BIT] == $past(tc_enable_in[DIC_CH1_BIT]))
    else $error("End event not recorded");

  a_err_event_raw: assert property (
    @(posedge clock_in) disable iff (rst_in)
    err_event_in[DIC_CH0_BIT] && !err_enable_in[DIC_CH0_BIT]
    |=> raw_err_out[DIC_CH0_BIT] && !masked_err_out[DIC_CH0_BIT])
    else $error("Error event not held before mask");

  a_event_beats_clear: assert property (
    @(posedge clock_in) disable iff (rst_in)
    tc_clear[DIC_CH0_BIT] && tc_event_in[DIC_CH0_BIT]
    |=> raw_tc_out[DIC_CH0_BIT] &&
        masked_tc_out[DIC_CH0_BIT] == $past(tc_enable_in[DIC_CH0_BIT]))
    else $error("Clear beat a simultaneous end event");

  a_err_beats_clear: assert property (
    @(posedge clock_in) disable iff (rst_in)
    err_clear[DIC_CH1_BIT] && err_event_in[DIC_CH1_BIT]
    |=> raw_err_out[DIC_CH1_BIT] &&
        masked_err_out[DIC_CH1_BIT] == $past(err_enable_in[DIC_CH1_BIT]))
    else $error("Clear beat a simultaneous error event");

  a_rdata_one_cycle: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !bus_in.rd |=> rdata_out == DIC_READ_ZERO)
    else $error("Read data outside the answer cycle");

  a_irq_level: assert property (
    @(posedge clock_in) disable iff (rst_in)
    irq_out == |(state.evt_status & state.evt_mask))
    else $error("Interrupt does not match masked status");

  a_read_clears: assert property (
    @(posedge clock_in) disable iff (rst_in)
    rd_evt_status && !(|evt_set) |=> state.evt_status == '0)
    else $error("Event status read did not clear");

  a_status_event_wins: assert property (
    @(posedge clock_in) disable iff (rst_in)
    rd_evt_status && err_event_in[DIC_CH1_BIT]
    |=> state.evt_status[CHANNELS + DIC_CH1_BIT])
    else $error("Event status read beat a new event");

endmodule

// >>> verilog/dic_pkg_cell.sv
// Shared constants, carrier types and the per-channel flag cell
`timescale 1ns/1ps

package dic_pkg;

  // ************************************************************
  // Widths and channel fields
  // ************************************************************
  localparam int DIC_DATA_W = 32;
  localparam int DIC_ADDR_W = 8;
  localparam int DIC_CHANNELS = 2;
  localparam int DIC_CH0_BIT = 0;
  localparam int DIC_CH1_BIT = 1;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_COMBINED = 8'h00;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_TC_STATUS = 8'h04;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_TC_CLEAR = 8'h08;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_ERR_STATUS = 8'h0c;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_ERR_CLEAR = 8'h10;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_RAW_TC = 8'h14;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_RAW_ERR = 8'h18;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_EVT_STATUS = 8'h20;
  localparam logic [DIC_ADDR_W-1:0] DIC_OFS_EVT_MASK = 8'h24;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic DIC_FLAG_RESET = 1'h0;
  localparam logic [DIC_DATA_W-1:0] DIC_RDATA_RESET = 32'h0000_0000;
  localparam logic [DIC_DATA_W-1:0] DIC_READ_ZERO = 32'h0000_0000;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic [DIC_ADDR_W-1:0] addr;
    logic [DIC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dic_bus_req_t;

  // Set beats clear so an event in the clearing cycle survives
  function automatic logic dic_next_flag(input logic flag,
                                         input logic set,
                                         input logic clear);
    dic_next_flag = set | (flag & ~clear);
  endfunction

endpackage

module dic_flag_cell
  import dic_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  typedef struct packed {
    logic flag;
  } dic_cell_state_t;

  dic_cell_state_t state;
  dic_cell_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.flag = dic_next_flag(state.flag, set_in, clear_in);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state.flag <= DIC_FLAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign flag_out = state.flag;

endmodule

// >>> verification/dic_irq_clear_status_test.sv
// Self-checking bench for the interrupt clear and status block
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module dic_irq_clear_status_test
  import dic_pkg::*;
;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  dic_bus_req_t bus = '0;
  logic [DIC_DATA_W-1:0] rdata;
  logic [1:0] tc_ev = 2'h0;
  logic [1:0] err_ev = 2'h0;
  logic [1:0] tc_en = 2'h0;
  logic [1:0] err_en = 2'h0;
  logic [1:0] raw_tc;
  logic [1:0] raw_err;
  logic [1:0] m_tc;
  logic [1:0] m_err;
  logic [1:0] comb;
  logic irq;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [7:0] reg_offs [9] = '{DIC_OFS_COMBINED,
    DIC_OFS_TC_STATUS, DIC_OFS_TC_CLEAR, DIC_OFS_ERR_STATUS,
    DIC_OFS_ERR_CLEAR, DIC_OFS_RAW_TC, DIC_OFS_RAW_ERR,
    DIC_OFS_EVT_STATUS, DIC_OFS_EVT_MASK};

  dic_irq_clear_status #(.CHANNELS(2)) i_dic_irq_clear_status (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .bus_in(bus),
    .rdata_out(rdata),
    .tc_event_in(tc_ev),
    .err_event_in(err_ev),
    .tc_enable_in(tc_en),
    .err_enable_in(err_en),
    .raw_tc_out(raw_tc),
    .raw_err_out(raw_err),
    .masked_tc_out(m_tc),
    .masked_err_out(m_err),
    .combined_status_out(comb),
    .irq_out(irq)
  );

  always #2 clock_in = ~clock_in;

  // ************************************************************
  // Verdict and hang guard
  // ************************************************************
  task give_verdict;
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is about a hundred cycles; generous ceiling
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ************************************************************
  // Bus and event helpers
  // ************************************************************
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'h1;
    @(posedge clock_in);
    bus.wr <= 1'h0;
    #1;
  endtask

  // Read data lives only in the cycle after the strobe edge
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    bus.addr <= a;
    bus.rd <= 1'h1;
    @(posedge clock_in);
    bus.rd <= 1'h0;
    #1;
    `CHK(rdata, e)
  endtask

  task fire(input logic [1:0] t, input logic [1:0] e);
    @(posedge clock_in);
    tc_ev <= t;
    err_ev <= e;
    @(posedge clock_in);
    tc_ev <= 2'h0;
    err_ev <= 2'h0;
    #1;
  endtask

  task flags(input logic [1:0] rt, input logic [1:0] mt,
             input logic [1:0] re, input logic [1:0] me, input logic i);
    `CHK(raw_tc, rt)
    `CHK(m_tc, mt)
    `CHK(raw_err, re)
    `CHK(m_err, me)
    `CHK(comb, mt | me)
    `CHK(irq, i)
  endtask

  // Irq is registered, so allow it a short bounded settle
  task irq_low;
    int k;
    k = 0;
    while (irq !== 1'h0 && k < 4) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    `CHK(irq, 1'h0)
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'h0;
    #1;
    flags(2'h0, 2'h0, 2'h0, 2'h0, 1'h0);
    foreach (reg_offs[n]) rd(reg_offs[n], 32'h0000_0000);
    @(posedge clock_in);
    tc_en <= 2'h3;
    err_en <= 2'h2;
    wr(DIC_OFS_EVT_MASK, 32'h0000_0001);
    rd(DIC_OFS_EVT_MASK, 32'h0000_0001);
    fire(2'h3, 2'h0);
    flags(2'h3, 2'h3, 2'h0, 2'h0, 1'h1);
    rd(DIC_OFS_TC_STATUS, 32'h0000_0003);
    rd(DIC_OFS_RAW_TC, 32'h0000_0003);
    rd(DIC_OFS_COMBINED, 32'h0000_0003);
    @(posedge clock_in);
    #1;
    `CHK(rdata, 32'h0000_0000)
    wr(DIC_OFS_TC_CLEAR, 32'h0000_0000);
    flags(2'h3, 2'h3, 2'h0, 2'h0, 1'h1);
    wr(DIC_OFS_TC_CLEAR, 32'h0000_0002);
    flags(2'h1, 2'h1, 2'h0, 2'h0, 1'h1);
    rd(DIC_OFS_TC_CLEAR, 32'h0000_0000);
    wr(DIC_OFS_TC_CLEAR, 32'h0000_0001);
    flags(2'h0, 2'h0, 2'h0, 2'h0, 1'h1);
    rd(DIC_OFS_EVT_STATUS, 32'h0000_0003);
    irq_low();
    rd(DIC_OFS_EVT_STATUS, 32'h0000_0000);
    // Channel 0 error held back by its enable
    fire(2'h0, 2'h3);
    flags(2'h0, 2'h0, 2'h3, 2'h2, 1'h0);
    rd(DIC_OFS_ERR_STATUS, 32'h0000_0002);
    rd(DIC_OFS_RAW_ERR, 32'h0000_0003);
    rd(DIC_OFS_COMBINED, 32'h0000_0002);
    @(posedge clock_in);
    err_en <= 2'h3;
    repeat (2) @(posedge clock_in);
    #1;
    `CHK(m_err, 2'h3)
    rd(DIC_OFS_ERR_STATUS, 32'h0000_0003);
    wr(DIC_OFS_ERR_CLEAR, 32'h0000_0000);
    flags(2'h0, 2'h0, 2'h3, 2'h3, 1'h0);
    wr(DIC_OFS_ERR_CLEAR, 32'h0000_0002);
    flags(2'h0, 2'h0, 2'h1, 2'h1, 1'h0);
    wr(DIC_OFS_ERR_CLEAR, 32'h0000_0001);
    flags(2'h0, 2'h0, 2'h0, 2'h0, 1'h0);
    rd(DIC_OFS_ERR_STATUS, 32'h0000_0000);
    rd(DIC_OFS_EVT_STATUS, 32'h0000_000c);
    wr(DIC_OFS_EVT_MASK, 32'h0000_0008);
    fire(2'h0, 2'h1);
    flags(2'h0, 2'h0, 2'h1, 2'h1, 1'h0);
    fire(2'h0, 2'h2);
    flags(2'h0, 2'h0, 2'h3, 2'h3, 1'h1);
    rd(DIC_OFS_EVT_STATUS, 32'h0000_000c);
    irq_low();
    // Event in the same cycle as its clear must survive
    fire(2'h2, 2'h0);
    @(posedge clock_in);
    bus.addr <= DIC_OFS_TC_CLEAR;
    bus.wdata <= 32'h0000_0003;
    bus.wr <= 1'h1;
    tc_ev <= 2'h1;
    @(posedge clock_in);
    bus.wr <= 1'h0;
    tc_ev <= 2'h0;
    #1;
    `CHK(raw_tc, 2'h1)
    `CHK(m_tc, 2'h1)
    rd(8'h40, 32'h0000_0000);
    wr(8'h40, 32'hffff_ffff);
    rd(DIC_OFS_EVT_MASK, 32'h0000_0008);
    wr(DIC_OFS_TC_CLEAR, 32'h0000_0003);
    @(posedge clock_in);
    tc_en <= 2'h0;
    fire(2'h2, 2'h0);
    flags(2'h2, 2'h0, 2'h3, 2'h3, 1'h0);
    rd(DIC_OFS_TC_STATUS, 32'h0000_0000);
    // Error in the clearing cycle survives the clear
    @(posedge clock_in);
    bus.addr <= DIC_OFS_ERR_CLEAR;
    bus.wdata <= 32'h0000_0003;
    bus.wr <= 1'h1;
    err_ev <= 2'h2;
    @(posedge clock_in);
    bus.wr <= 1'h0;
    err_ev <= 2'h0;
    #1;
    `CHK(raw_err, 2'h2)
    `CHK(m_err, 2'h2)
    // Event in the cycle of a status read is not lost
    @(posedge clock_in);
    bus.addr <= DIC_OFS_EVT_STATUS;
    bus.rd <= 1'h1;
    err_ev <= 2'h2;
    @(posedge clock_in);
    bus.rd <= 1'h0;
    err_ev <= 2'h0;
    #1;
    `CHK(rdata, 32'h0000_000b)
    rd(DIC_OFS_EVT_STATUS, 32'h0000_0008);
    irq_low();
    give_verdict();
  end
endmodule
